/* rft_timing_regs.svh */
// Register map, reset values and timing constants of the RF timing block
`ifndef RFT_TIMING_REGS_SVH
`define RFT_TIMING_REGS_SVH

// Register indices; byte address is four times the index
`define RFT_IDX_PROTO 8'h01
`define RFT_IDX_DLY_HI 8'h04
`define RFT_IDX_DLY_LO 8'h05
`define RFT_IDX_PUL_OVR 8'h06
`define RFT_IDX_NR_WIN 8'h07
`define RFT_IDX_IRQ_STAT 8'h0c
`define RFT_IDX_IRQ_MASK 8'h0d
`define RFT_IDX_CMD 8'h0e
`define RFT_IDX_STATE 8'h0f

// Reset and preset values
`define RFT_RST_PROTO 3'h0
`define RFT_RST_DLY_HI 8'hc2
`define RFT_RST_DLY_LO 8'h00
`define RFT_RST_PUL_OVR 8'h00
`define RFT_RST_NR_WIN 8'h0e
`define RFT_CMD_CLR_BUF 8'h0f

// Field positions
`define RFT_TRIG_HI 7
`define RFT_TRIG_LO 6
`define RFT_LEN_HI_MSB 5
`define RFT_STAT_NR 0
`define RFT_STAT_GO 1
`define RFT_NSTAT 2

// Clock and step times
`define RFT_CLK_NS 8
`define RFT_DLY_STEP_NS 590
`define RFT_NR_STEP_NS 37760
// Pulse times in tenths of a nanosecond
`define RFT_CLK_DNS 80
`define RFT_PUL_STEP_DNS 737
`define RFT_PUL_VIC_DNS 94400
`define RFT_PUL_A106_DNS 23600
`define RFT_PUL_A212_DNS 14000
`define RFT_PUL_A424_DNS 7370
`define RFT_PUL_A848_DNS 4420

// No-response presets in microseconds, stored in 37.76 us steps
`define RFT_NR_VIC_HI_US 755
`define RFT_NR_VIC_LO_US 1812
`define RFT_NR_OTHER_US 529
`define RFT_NR_STEP_CUS 3776
`define RFT_NR_CODE(u) (((u) * 100 + `RFT_NR_STEP_CUS / 2) / `RFT_NR_STEP_CUS)

`endif

/* rft_pkg.sv */
// Types of the RF timing block
package rft_pkg;

    typedef enum logic [2:0] {
        RFT_PROTO_VIC_LO = 3'b000,
        RFT_PROTO_VIC_HI = 3'b001,
        RFT_PROTO_A106 = 3'b010,
        RFT_PROTO_A212 = 3'b011,
        RFT_PROTO_A424 = 3'b100,
        RFT_PROTO_A848 = 3'b101,
        RFT_PROTO_OTH0 = 3'b110,
        RFT_PROTO_OTH1 = 3'b111
    } rft_proto_e;

    typedef enum logic [0:0] {
        RFT_NR_IDLE = 1'b0,
        RFT_NR_RUN = 1'b1
    } rft_nr_state_e;

endpackage : rft_pkg

/* rft_timing.sv */
// RF reader transmit/receive timing timers with AHB-Lite registers
// Operation
// - Delay count is 14 bits, low byte from register, 590 ns per count.
// - Expiry of the delay count starts the pending transmission.
// - Whole delay count zero disables the timer, no delay.
// - Delay low byte loads zero at reset, enable low, protocol write.
// - Override zero gives protocol-defined modulation pulse length.
// - Override N gives pulses of N times 73.7 ns.
// - Pulse presets: 9.44 us vicinity, 2.36/1.4/0.737/0.442 us type A.
// - Override loads zero at reset, enable low, protocol write.
// - Silence past the window raises interrupt and sets no-response flag.
// - Silence timer starts at end of transmit EOF, ends at response.
// - Window is register value times 37.76 us, valid 1 to 255.
// - Protocol presets window: 755 us, 1812 us vicinity, else 529 us.
// - Clear-buffer command after transmit complete suppresses no-response.
// - No-response interrupt only with the vicinity protocol selected.
// - Window register loads 0x0E at reset and enable low, protocol preset on protocol write.
// - Two-bit trigger select picks the event starting the delay count.
`timescale 1ns/100ps
`default_nettype none
`include "rft_timing_regs.svh"

module rft_timing #(
    parameter int NR_STEP_CYC = `RFT_NR_STEP_NS / `RFT_CLK_NS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic enable,
    input wire logic tx_sof_begin,
    input wire logic tx_sof_end,
    input wire logic rx_sof_begin,
    input wire logic rx_sof_end,
    input wire logic tx_eof_end,
    input wire logic tx_complete,
    input wire logic rx_resp_begin,
    input wire logic mod_request,
    output logic tx_go,
    output logic mod_pulse,
    output logic irq
);
    import rft_pkg::*;

    localparam logic [9:0] DLY_STEP = 10'(`RFT_DLY_STEP_NS);
    localparam logic [9:0] CLK_NS = 10'(`RFT_CLK_NS);
    localparam logic [17:0] CLK_DNS = 18'(`RFT_CLK_DNS);
    localparam logic [12:0] NR_LAST = 13'(NR_STEP_CYC - 1);

    // Enable pin synchroniser, accepted when stages two and three agree
    logic en_s1_q, en_s2_q, en_s3_q, en_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            en_s1_q <= 1'b0;
            en_s2_q <= 1'b0;
            en_s3_q <= 1'b0;
            en_q <= 1'b0;
        end
        else
        begin
            en_s1_q <= enable;
            en_s2_q <= en_s1_q;
            en_s3_q <= en_s2_q;
            if (en_s2_q == en_s3_q)
                en_q <= en_s3_q;
        end
    end

    // AHB-Lite address phase capture
    logic wr_pend_q;
    logic [7:0] wr_idx_q;
    logic addr_ok;
    logic rd_take;
    logic [7:0] a_idx;
    assign addr_ok = hsel && hready && htrans[1];
    assign rd_take = addr_ok && !hwrite;
    assign a_idx = haddr[9:2];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 8'h00;
        end
        else
        begin
            wr_pend_q <= addr_ok && hwrite && (haddr[31:10] == 22'h00_0000);
            wr_idx_q <= a_idx;
        end
    end

    logic wr_proto, wr_hi, wr_lo, wr_ovr, wr_win, wr_mask, wr_cmd;
    assign wr_proto = wr_pend_q && wr_idx_q == `RFT_IDX_PROTO;
    assign wr_hi = wr_pend_q && wr_idx_q == `RFT_IDX_DLY_HI;
    assign wr_lo = wr_pend_q && wr_idx_q == `RFT_IDX_DLY_LO;
    assign wr_ovr = wr_pend_q && wr_idx_q == `RFT_IDX_PUL_OVR;
    assign wr_win = wr_pend_q && wr_idx_q == `RFT_IDX_NR_WIN;
    assign wr_mask = wr_pend_q && wr_idx_q == `RFT_IDX_IRQ_MASK;
    assign wr_cmd = wr_pend_q && wr_idx_q == `RFT_IDX_CMD;

    // Timing registers
    rft_proto_e proto_q;
    logic [7:0] dly_hi_q, dly_lo_q, pul_ovr_q, nr_win_q;
    logic is_vic;
    logic [7:0] nr_preset;
    assign is_vic = proto_q == RFT_PROTO_VIC_LO || proto_q == RFT_PROTO_VIC_HI;

    always_comb
    begin
        case (rft_proto_e'(hwdata[2:0]))
            RFT_PROTO_VIC_HI: nr_preset = 8'(`RFT_NR_CODE(`RFT_NR_VIC_HI_US));
            RFT_PROTO_VIC_LO: nr_preset = 8'(`RFT_NR_CODE(`RFT_NR_VIC_LO_US));
            default: nr_preset = 8'(`RFT_NR_CODE(`RFT_NR_OTHER_US));
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            proto_q <= rft_proto_e'(`RFT_RST_PROTO);
            dly_hi_q <= `RFT_RST_DLY_HI;
            dly_lo_q <= `RFT_RST_DLY_LO;
            pul_ovr_q <= `RFT_RST_PUL_OVR;
            nr_win_q <= `RFT_RST_NR_WIN;
        end
        else if (!en_q)
        begin
            dly_hi_q <= `RFT_RST_DLY_HI;
            dly_lo_q <= `RFT_RST_DLY_LO;
            pul_ovr_q <= `RFT_RST_PUL_OVR;
            nr_win_q <= `RFT_RST_NR_WIN;
        end
        else if (wr_proto)
        begin
            proto_q <= rft_proto_e'(hwdata[2:0]);
            dly_hi_q <= `RFT_RST_DLY_HI;
            dly_lo_q <= `RFT_RST_DLY_LO;
            pul_ovr_q <= `RFT_RST_PUL_OVR;
            nr_win_q <= nr_preset;
        end
        else
        begin
            if (wr_hi)
                dly_hi_q <= hwdata[7:0];
            if (wr_lo)
                dly_lo_q <= hwdata[7:0];
            if (wr_ovr)
                pul_ovr_q <= hwdata[7:0];
            if (wr_win)
                nr_win_q <= hwdata[7:0];
        end
    end

    // Delay timer
    logic [13:0] dly_len;
    logic dly_trig;
    logic dly_run_q, tx_go_q, dly_tick;
    logic [13:0] dly_cnt_q;
    logic [9:0] dly_acc_q;
    // 14-bit length, low byte from its register
    assign dly_len = {dly_hi_q[`RFT_LEN_HI_MSB:0], dly_lo_q};

    always_comb
    begin
        // start event chosen by trigger select
        case (dly_hi_q[`RFT_TRIG_HI:`RFT_TRIG_LO])
            2'b00: dly_trig = tx_sof_begin;
            2'b01: dly_trig = tx_sof_end;
            2'b10: dly_trig = rx_sof_begin;
            2'b11: dly_trig = rx_sof_end;
            default: dly_trig = 1'b0;
        endcase
    end

    // 590 ns tick from an 8 ns accumulator
    assign dly_tick = dly_run_q && (dly_acc_q >= DLY_STEP - CLK_NS);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dly_run_q <= 1'b0;
            dly_cnt_q <= 14'h0000;
            dly_acc_q <= 10'h000;
            tx_go_q <= 1'b0;
        end
        else
        begin
            tx_go_q <= 1'b0;
            if (!en_q || wr_proto)
                dly_run_q <= 1'b0;
            // zero length never arms the timer
            else if (dly_trig && dly_len != 14'h0000)
            begin
                dly_run_q <= 1'b1;
                dly_cnt_q <= dly_len;
                dly_acc_q <= 10'h000;
            end
            else if (dly_run_q)
            begin
                if (dly_tick)
                begin
                    dly_acc_q <= dly_acc_q + CLK_NS - DLY_STEP;
                    dly_cnt_q <= dly_cnt_q - 14'h0001;
                    if (dly_cnt_q == 14'h0001)
                    begin
                        dly_run_q <= 1'b0;
                        tx_go_q <= 1'b1;
                    end
                end
                else
                    dly_acc_q <= dly_acc_q + CLK_NS;
            end
        end
    end

    // Modulation pulse length, measured in tenths of a nanosecond
    logic [17:0] pul_tgt, pul_tgt_q, pul_acc_q;
    logic pul_q;
    always_comb
    begin
        if (pul_ovr_q != 8'h00)
            pul_tgt = 18'(pul_ovr_q * `RFT_PUL_STEP_DNS);
        else
        begin
            case (proto_q)
                RFT_PROTO_A106: pul_tgt = 18'(`RFT_PUL_A106_DNS);
                RFT_PROTO_A212: pul_tgt = 18'(`RFT_PUL_A212_DNS);
                RFT_PROTO_A424: pul_tgt = 18'(`RFT_PUL_A424_DNS);
                RFT_PROTO_A848: pul_tgt = 18'(`RFT_PUL_A848_DNS);
                default: pul_tgt = 18'(`RFT_PUL_VIC_DNS);
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pul_q <= 1'b0;
            pul_acc_q <= 18'h0_0000;
            pul_tgt_q <= 18'h0_0000;
        end
        else if (!en_q)
            pul_q <= 1'b0;
        else if (!pul_q && mod_request)
        begin
            pul_q <= 1'b1;
            pul_acc_q <= CLK_DNS;
            pul_tgt_q <= pul_tgt;
        end
        else if (pul_q)
        begin
            if (pul_acc_q >= pul_tgt_q)
                pul_q <= 1'b0;
            else
                pul_acc_q <= pul_acc_q + CLK_DNS;
        end
    end

    // No-response timer
    rft_nr_state_e nr_state_q;
    logic [7:0] nr_left_q;
    logic [12:0] nr_step_q;
    logic nr_ev_q, tx_done_q, supp_q, supp_hit;
    assign supp_hit = wr_cmd && hwdata[7:0] == `RFT_CMD_CLR_BUF && tx_done_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_done_q <= 1'b0;
            supp_q <= 1'b0;
        end
        else if (tx_sof_begin || !en_q)
        begin
            tx_done_q <= 1'b0;
            supp_q <= 1'b0;
        end
        else
        begin
            if (tx_complete)
                tx_done_q <= 1'b1;
            if (supp_hit)
                supp_q <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            nr_state_q <= RFT_NR_IDLE;
            nr_left_q <= 8'h00;
            nr_step_q <= 13'h0000;
            nr_ev_q <= 1'b0;
        end
        else
        begin
            nr_ev_q <= 1'b0;
            case (nr_state_q)
                RFT_NR_IDLE:
                begin
                    // start at end of transmit EOF
                    if (en_q && tx_eof_end && is_vic && !supp_q
                        && nr_win_q != 8'h00)
                    begin
                        nr_state_q <= RFT_NR_RUN;
                        nr_left_q <= nr_win_q;
                        nr_step_q <= 13'h0000;
                    end
                end
                RFT_NR_RUN:
                begin
                    if (!en_q || rx_resp_begin || supp_hit || supp_q
                        || wr_proto)
                        nr_state_q <= RFT_NR_IDLE;
                    // window counted in 37.76 us steps
                    else if (nr_step_q == NR_LAST)
                    begin
                        nr_step_q <= 13'h0000;
                        nr_left_q <= nr_left_q - 8'h01;
                        if (nr_left_q == 8'h01)
                        begin
                            nr_state_q <= RFT_NR_IDLE;
                            nr_ev_q <= 1'b1;
                        end
                    end
                    else
                        nr_step_q <= nr_step_q + 13'h0001;
                end
                default: nr_state_q <= RFT_NR_IDLE;
            endcase
        end
    end

    // Interrupt status, cleared by reading; a new event wins over the read
    logic [`RFT_NSTAT-1:0] stat_q, mask_q, stat_set;
    logic irq_q;
    assign stat_set = {tx_go_q, nr_ev_q};
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stat_q <= '0;
            mask_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            if (rd_take && a_idx == `RFT_IDX_IRQ_STAT)
                stat_q <= stat_set;
            else
                stat_q <= stat_q | stat_set;
            if (wr_mask)
                mask_q <= hwdata[`RFT_NSTAT-1:0];
            irq_q <= |(stat_q & mask_q);
        end
    end

    // Read data, registered in the address phase
    logic [31:0] rdata_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_q <= 32'h0000_0000;
        else if (rd_take)
        begin
            rdata_q <= 32'h0000_0000;
            if (haddr[31:10] == 22'h00_0000)
            begin
                case (a_idx)
                    `RFT_IDX_PROTO: rdata_q[2:0] <= proto_q;
                    `RFT_IDX_DLY_HI: rdata_q[7:0] <= dly_hi_q;
                    `RFT_IDX_DLY_LO: rdata_q[7:0] <= dly_lo_q;
                    `RFT_IDX_PUL_OVR: rdata_q[7:0] <= pul_ovr_q;
                    `RFT_IDX_NR_WIN: rdata_q[7:0] <= nr_win_q;
                    `RFT_IDX_IRQ_STAT: rdata_q[`RFT_NSTAT-1:0] <= stat_q;
                    `RFT_IDX_IRQ_MASK: rdata_q[`RFT_NSTAT-1:0] <= mask_q;
                    `RFT_IDX_STATE: rdata_q[4:0] <= {en_q, supp_q, pul_q,
                        nr_state_q == RFT_NR_RUN, dly_run_q};
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    logic ready_q, resp_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ready_q <= 1'b0;
            resp_q <= 1'b0;
        end
        else
        begin
            ready_q <= 1'b1;
            resp_q <= 1'b0;
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = ready_q;
    assign hresp = resp_q;
    assign tx_go = tx_go_q;
    assign mod_pulse = pul_q;
    assign irq = irq_q;

    // Helper: cycles the pulse has been high
    logic [11:0] pul_cyc_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pul_cyc_q <= 12'h000;
        else if (pul_q)
            pul_cyc_q <= pul_cyc_q + 12'h001;
        else
            pul_cyc_q <= 12'h000;
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_delay_zero_off:
    assert property (en_q && !wr_proto && !dly_run_q && dly_trig
        && dly_len == 14'h0000 |=> !dly_run_q && !tx_go_q)
    else $error("zero delay count armed the timer");

    a_delay_load_cnt:
    assert property (en_q && !wr_proto && dly_trig && dly_len != 14'h0000
        |=> dly_run_q && dly_cnt_q == $past(dly_len))
    else $error("delay count not loaded on trigger");

    a_delay_go_end:
    assert property (tx_go_q |-> $past(dly_run_q) && $past(dly_tick)
        && $past(dly_cnt_q) == 14'h0001 && !dly_run_q)
    else $error("transmit start without expiry");

    a_low_defaults:
    assert property (!en_q |=> dly_lo_q == 8'h00 && pul_ovr_q == 8'h00
        && nr_win_q == 8'h0e)
    else $error("defaults not held while disabled");

    a_proto_preset:
    assert property (en_q && wr_proto && hwdata[2:0] == 3'b001
        |=> nr_win_q == 8'h14 && pul_ovr_q == 8'h00 && dly_lo_q == 8'h00)
    else $error("protocol write preset wrong");

    a_pulse_len_ovr:
    assert property ($fell(pul_q) && $past(en_q) |->
        $past(pul_cyc_q) + 12'h001 ==
        12'(($past(pul_tgt_q) + 18'd79) / 18'd80))
    else $error("modulation pulse length wrong");

    a_nr_vic_only:
    assert property (nr_state_q == RFT_NR_RUN |-> is_vic || $past(wr_proto))
    else $error("no-response timer outside vicinity protocol");

    a_nr_start_eof:
    assert property (nr_state_q == RFT_NR_IDLE && en_q && tx_eof_end
        && is_vic && !supp_q && nr_win_q != 8'h00
        |=> nr_state_q == RFT_NR_RUN && nr_left_q == $past(nr_win_q))
    else $error("no-response timer did not start");

    a_nr_resp_stop:
    assert property (nr_state_q == RFT_NR_RUN && rx_resp_begin
        |=> nr_state_q == RFT_NR_IDLE && !nr_ev_q)
    else $error("response did not stop timer");

    a_nr_suppress:
    assert property (supp_q |-> !nr_ev_q ##1 nr_state_q == RFT_NR_IDLE)
    else $error("suppressed exchange raised no-response");

    a_nr_step_dec:
    assert property (nr_state_q == RFT_NR_RUN && en_q && !rx_resp_begin
        && !supp_q && !supp_hit && !wr_proto && nr_step_q == NR_LAST
        |=> nr_left_q == $past(nr_left_q) - 8'h01)
    else $error("window step not counted");

    a_nr_flag_set:
    assert property (nr_ev_q |=> stat_q[`RFT_STAT_NR])
    else $error("no-response flag not set");

endmodule : rft_timing

`default_nettype wire

/* rft_tag_model.sv */
// Behavioural tag: answers some time after the reader's end of frame
`timescale 1ns/100ps
`default_nettype none

module rft_tag_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tx_eof_end,
    input wire logic [15:0] resp_dly,
    output logic rx_resp_begin
);
    logic [15:0] cnt_q;

    // reply counted from end of EOF, zero means silent
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q <= 16'h0000;
            rx_resp_begin <= 1'b0;
        end
        else
        begin
            rx_resp_begin <= (cnt_q == 16'h0001);
            if (tx_eof_end)
                cnt_q <= resp_dly;
            else if (cnt_q != 16'h0000)
                cnt_q <= cnt_q - 16'h0001;
        end
    end
endmodule : rft_tag_model

`default_nettype wire

/* tb_top.sv */
// Self-checking bench of the RF timing block
`timescale 1ns/100ps
`default_nettype none
`include "rft_timing_regs.svh"

module tb_top;
    import rft_pkg::*;
    logic hclk, hresetn, hsel, hwrite, enable;
    logic [31:0] haddr, hwdata, hrdata, rd, seed;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [6:0] ev;
    logic [15:0] resp_dly;
    wire hready, hresp, tx_go, mod_pulse, irq, rx_resp;
    int n_fail = 0, total_checks = 0, n, len, e;

    rft_timing #(.NR_STEP_CYC(8)) u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .enable(enable),
        .tx_sof_begin(ev[0]), .tx_sof_end(ev[1]), .rx_sof_begin(ev[2]),
        .rx_sof_end(ev[3]), .tx_eof_end(ev[4]), .tx_complete(ev[5]),
        .rx_resp_begin(rx_resp), .mod_request(ev[6]), .tx_go(tx_go),
        .mod_pulse(mod_pulse), .irq(irq));
    rft_tag_model u_tag (.hclk(hclk), .hresetn(hresetn),
        .tx_eof_end(ev[4]), .resp_dly(resp_dly), .rx_resp_begin(rx_resp));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] exp_win(input int p);
        return (p == 1) ? 8'h14 : (p == 0) ? 8'h30 : 8'h0e;
    endfunction : exp_win

    task automatic chk(input string nm, input logic [31:0] x, y);
        total_checks++;
        if (x !== y)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, x, y);
        end
    endtask : chk
    task automatic chk_rng(input string nm, input int lo, hi, y);
        total_checks++;
        if (y < lo || y > hi)
        begin
            n_fail++;
            $display("unexpected %s: expected %0d..%0d seen %0d", nm, lo,
                hi, y);
        end
    endtask : chk_rng
    task automatic xfer(input logic w, input logic [7:0] idx,
        input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {22'h00_0000, idx, 2'b00};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", 0, {31'h0, hresp});
    endtask : xfer
    task automatic fire(input int k);
        @(posedge hclk);
        ev <= 7'(1 << k);
        @(posedge hclk);
        ev <= 7'h00;
    endtask : fire
    task automatic silence(input int p, input logic [15:0] dly, input int k,
        input logic [31:0] exp);
        xfer(1, `RFT_IDX_PROTO, p);
        xfer(1, `RFT_IDX_NR_WIN, 32'h0000_0002);
        xfer(0, `RFT_IDX_IRQ_STAT, 0);
        resp_dly <= dly;
        if (k >= 0)
            fire(k);
        if (k >= 0)
            xfer(1, `RFT_IDX_CMD, `RFT_CMD_CLR_BUF);
        fire(4);
        n = 0;
        while (irq !== 1'b1 && n < 60)
        begin
            @(posedge hclk);
            n++;
        end
        // Window of 2 steps of 8 cycles, plus flag and irq flops
        if (exp[0])
            chk_rng("silence cycles", 2 * 8 + 2, 2 * 8 + 4, n);
        chk("irq", exp, {31'h0, irq});
        xfer(0, `RFT_IDX_IRQ_STAT, 0);
        chk("no-response flag", exp, rd & 32'h0000_0001);
        repeat (3) @(posedge hclk);
        chk("irq after read", 0, {31'h0, irq});
    endtask : silence
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    initial
    begin
        repeat (60000) @(posedge hclk);
        n_fail++;
        test_done;
    end
    initial
    begin
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        hsize = 3'h2;
        ev = 7'h00;
        resp_dly = 16'h0000;
        enable = 1'b1;
        seed = 32'h9874;
        hresetn = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (8) @(posedge hclk);
        xfer(0, `RFT_IDX_DLY_LO, 0);
        chk("low byte reset", 0, rd);
        xfer(0, `RFT_IDX_PUL_OVR, 0);
        chk("override reset", 0, rd);
        xfer(0, `RFT_IDX_NR_WIN, 0);
        chk("window reset", 32'h0000_000e, rd);
        xfer(0, 8'h20, 0);
        chk("unmapped", 0, rd);
        for (int i = 5; i < 8; i++)
        begin
            seed = lfsr(seed);
            xfer(1, 8'(i), seed);
            xfer(0, 8'(i), 0);
            chk("readback", {24'h0, seed[7:0]}, rd);
        end
        @(posedge hclk);
        enable <= 1'b0;
        repeat (8) @(posedge hclk);
        enable <= 1'b1;
        repeat (8) @(posedge hclk);
        xfer(0, `RFT_IDX_DLY_LO, 0);
        chk("low byte enable low", 0, rd);
        xfer(0, `RFT_IDX_NR_WIN, 0);
        chk("window enable low", 32'h0000_000e, rd);
        for (int p = 0; p < 8; p++)
        begin
            xfer(1, `RFT_IDX_DLY_LO, 32'h0000_00a5);
            xfer(1, `RFT_IDX_PUL_OVR, 32'h0000_005a);
            xfer(1, `RFT_IDX_PROTO, p);
            xfer(0, `RFT_IDX_DLY_LO, 0);
            chk("low byte preset", 0, rd);
            xfer(0, `RFT_IDX_PUL_OVR, 0);
            chk("override preset", 0, rd);
            xfer(0, `RFT_IDX_NR_WIN, 0);
            chk("window preset", {24'h0, exp_win(p)}, rd);
        end
        for (int t = 0; t < 4; t++)
        begin
            seed = lfsr(seed);
            len = 1 + seed[1:0];
            xfer(1, `RFT_IDX_DLY_HI, t << 6);
            xfer(1, `RFT_IDX_DLY_LO, len);
            fire(t);
            n = 0;
            while (tx_go !== 1'b1 && n < 2000)
            begin
                @(posedge hclk);
                n++;
            end
            e = len * `RFT_DLY_STEP_NS / `RFT_CLK_NS;
            chk_rng("delay cycles", e - 2, e + 3, n);
        end
        xfer(1, `RFT_IDX_DLY_LO, 0);
        // Trigger select is still 11 from the last delay run
        fire(3);
        n = 0;
        while (tx_go !== 1'b1 && n < 300)
        begin
            @(posedge hclk);
            n++;
        end
        chk("zero delay idle", 300, n);
        for (int k = 0; k < 4; k++)
        begin
            seed = lfsr(seed);
            len = (k == 0) ? 1 : (k == 1) ? 255 : 1 + seed[7:0] % 255;
            e = (len * `RFT_PUL_STEP_DNS + `RFT_CLK_DNS - 1) / `RFT_CLK_DNS;
            if (k == 3)
                xfer(1, `RFT_IDX_PROTO, RFT_PROTO_A106);
            else
                xfer(1, `RFT_IDX_PUL_OVR, len);
            if (k == 3)
                e = `RFT_PUL_A106_DNS / `RFT_CLK_DNS;
            fire(6);
            n = 0;
            @(posedge hclk);
            while (mod_pulse === 1'b1 && n < 4000)
            begin
                n++;
                @(posedge hclk);
            end
            chk_rng("pulse cycles", e, e + 1, n);
        end
        xfer(1, `RFT_IDX_PUL_OVR, 32'h0000_00c3);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (8) @(posedge hclk);
        xfer(0, `RFT_IDX_PUL_OVR, 0);
        chk("override after reset", 0, rd);
        xfer(1, `RFT_IDX_IRQ_MASK, 32'h0000_0001);
        silence(RFT_PROTO_VIC_LO, 0, -1, 1);
        silence(RFT_PROTO_VIC_HI, 3, -1, 0);
        silence(RFT_PROTO_A106, 0, -1, 0);
        silence(RFT_PROTO_VIC_LO, 0, 5, 0);
        test_done;
    end
endmodule : tb_top

`default_nettype wire
